// >>> include/fsc_map.svh
// Constants of the frequency-scan control block: serial command codes,
// control-word bit positions, reset values and timing counts.
// Assumes inclusion by bare name from the design file.
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH

// ----------------------------------------
// Serial command codes (top nibble; the interval word uses the top two bits)
// ----------------------------------------
`define FSC_CMD_CTRL     4'h0
`define FSC_CMD_STEP_COUNT    4'h1
`define FSC_CMD_DF_LO    4'h2
`define FSC_CMD_DF_HI    4'h3
`define FSC_CMD_STEP_INTERVAL     2'h1
`define FSC_CMD_FS_LO    4'hC
`define FSC_CMD_FS_HI    4'hD

// ----------------------------------------
// Control word, interval word and frequency-step high word bits
// ----------------------------------------
`define FSC_B_DAC_EN     10
`define FSC_B_SINE       9
`define FSC_B_SQ_EN      8
`define FSC_B_EXT_INC    5
`define FSC_B_MARK_SEL   3
`define FSC_B_MARK_EN    2
`define FSC_B_STEP_INTERVAL_MODE  13
`define FSC_B_DF_NEG     11

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define FSC_CTRL_RST     12'h000
`define FSC_STEP_COUNT_RST    12'h002
`define FSC_STEP_INTERVAL_RST     11'h002
`define FSC_MIDSCALE     10'h200
`define FSC_PULSE_LEN    3'h4
`define FSC_LAST_BIT     4'hF
`define FSC_MULT1_M1     9'h000
`define FSC_MULT5_M1     9'h004
`define FSC_MULT100_M1   9'h063
`define FSC_MULT500_M1   9'h1F3

`endif

// >>> include/fsc_pkg.sv
// Types of the frequency-scan control block.
// Assumes fsc_map.svh on the include path.
package fsc_pkg;

  // Scan sequencer states
  typedef enum logic [1:0] {
    FSC_IDLE = 2'b00,
    FSC_RUN  = 2'b01,
    FSC_DONE = 2'b10
  } fsc_state_t;

  // Everything the serial port programs
  typedef struct packed {
    logic [23:0] start_frequency;
    logic [22:0] frequency_step;
    logic        step_neg;
    logic [11:0] step_count;
    logic        step_interval_by_cycles;
    logic [1:0]  step_interval_mult;
    logic [10:0] step_interval;
    logic [11:0] control;
  } fsc_cfg_t;

  // Asynchronous pins, synchronised together
  typedef struct packed {
    logic trigger;
    logic abort;
    logic standby;
    logic sclk;
    logic frame_n;
    logic serial_data_in;
  } fsc_pins_t;

endpackage : fsc_pkg

// >>> design/fsc_core.sv
// Frequency-scan control: serial write port, scan sequencer, phase
// accumulator, waveform select, square and marker outputs.
// Assumes all pins arrive asynchronously to clk_i and the serial clock
// is slow enough (well under clk_i / 2) to be sampled.
//
// Contract
// - Trigger rising edge starts programmed scan
// - Every scan starts at start_frequency
// - Each step adds or subtracts frequency_step, step_count steps
// - Internal mode: hold step_interval, then advance
// - External mode: later trigger edges step
// - Abort rising edge resets, output midscale
// - Standby high freezes accumulator and output
// - Standby low resumes scan where stopped
// - waveform_select picks sine or triangle
// - square_wave_out is inverted converter MSB
// - Marker enabled by D2, kind by D3
// - Marker: end of scan or 4-clock pulse
// - Data captured on serial clock falling edge
// - MSB first: control, address, data
`timescale 1ns/1ps
`default_nettype none
`include "fsc_map.svh"

module fsc_core (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Serial write port
  input  wire logic       serial_shift_clock_i,
  input  wire logic       frame_select_n_i,
  input  wire logic       serial_data_in_i,
  // Control pins
  input  wire logic       scan_trigger_pin_i,
  input  wire logic       scan_abort_pin_i,
  input  wire logic       power_save_pin_i,
  // Outputs
  output logic [9:0]      dac_data_o,
  output logic            converter_output_enable_o,
  output logic            square_wave_out_o,
  output logic            scan_marker_out_o,
  output logic            scan_active_o
);
  import fsc_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  fsc_pins_t pins_raw;
  fsc_pins_t meta_q;
  fsc_pins_t sync_q;
  fsc_pins_t prev_q;
  // All pins through one synchroniser bank
  assign pins_raw = '{trigger: scan_trigger_pin_i, abort: scan_abort_pin_i,
                      standby: power_save_pin_i, sclk: serial_shift_clock_i,
                      frame_n: frame_select_n_i, serial_data_in: serial_data_in_i};
  // Two stages, then one more for edge finding
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  logic trig_rise;
  logic abort_rise;
  logic sclk_fall;
  logic standby;
  // Edge strobes
  assign trig_rise  = sync_q.trigger & ~prev_q.trigger;
  assign abort_rise = sync_q.abort & ~prev_q.abort;
  assign sclk_fall  = ~sync_q.sclk & prev_q.sclk;
  assign standby    = sync_q.standby;

  // ----------------------------------------
  // Serial port and programmed settings
  // ----------------------------------------
  logic [15:0] shift_q, shift_d;
  logic [3:0]  bits_q, bits_d;
  fsc_cfg_t    cfg_q, cfg_d;
  logic [15:0] word;
  // Shift in MSB first; a word is taken only on its sixteenth bit
  always_comb begin
    shift_d = shift_q;
    bits_d  = bits_q;
    cfg_d   = cfg_q;
    word    = {shift_q[14:0], sync_q.serial_data_in};
    if (sync_q.frame_n) begin
      bits_d = 4'h0; // Frame high drops any partial word
    end else if (sclk_fall) begin
      shift_d = word;
      bits_d  = bits_q + 4'h1;
      if (bits_q == `FSC_LAST_BIT) begin
        if (word[15:14] == `FSC_CMD_STEP_INTERVAL) begin
          cfg_d.step_interval_by_cycles = ~word[`FSC_B_STEP_INTERVAL_MODE];
          cfg_d.step_interval_mult      = word[12:11];
          cfg_d.step_interval  = word[10:0];
        end else begin
          case (word[15:12])
            `FSC_CMD_CTRL:  cfg_d.control               = word[11:0];
            `FSC_CMD_STEP_COUNT: cfg_d.step_count            = word[11:0];
            `FSC_CMD_DF_LO: cfg_d.frequency_step[11:0]  = word[11:0];
            `FSC_CMD_DF_HI: begin
              cfg_d.frequency_step[22:12] = word[10:0];
              cfg_d.step_neg              = word[`FSC_B_DF_NEG];
            end
            `FSC_CMD_FS_LO: cfg_d.start_frequency[11:0]  = word[11:0];
            `FSC_CMD_FS_HI: cfg_d.start_frequency[23:12] = word[11:0];
            default: ; // Unused codes are ignored
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_q <= 16'h0000;
      bits_q  <= 4'h0;
      cfg_q   <= '{start_frequency: 24'h000000, frequency_step: 23'h000000,
                   step_neg: 1'b0, step_count: `FSC_STEP_COUNT_RST,
                   step_interval_by_cycles: 1'b0, step_interval_mult: 2'h0,
                   step_interval: `FSC_STEP_INTERVAL_RST, control: `FSC_CTRL_RST};
    end else begin
      shift_q <= shift_d;
      bits_q  <= bits_d;
      cfg_q   <= cfg_d;
    end
  end

  // ----------------------------------------
  // Scan sequencer and waveform path
  // ----------------------------------------
  fsc_state_t  state_q, state_d;
  logic [23:0] freq_q, freq_d;
  logic [11:0] left_q, left_d;
  logic [23:0] phase_q, phase_d;
  logic [8:0]  pre_q, pre_d;
  logic [10:0] ivl_q, ivl_d;
  logic [2:0]  pulse_q, pulse_d;
  logic [9:0]  dac_q, dac_d;
  logic        sq_q, sq_d;
  logic        mark_q, mark_d;
  logic [23:0] phase_next;
  logic [23:0] step_ext;
  logic [8:0]  mult_m1;
  logic        tick;
  logic        step;
  logic [8:0]  half_pos;
  logic [17:0] prod;
  logic [9:0]  amp;
  logic [9:0]  wave;

  assign phase_next = phase_q + freq_q;
  assign step_ext   = {1'b0, cfg_q.frequency_step};
  assign half_pos   = phase_q[22:14];
  // Parabolic half-wave stands in for the sine lookup: no table to load
  assign prod       = {9'h000, half_pos} * {9'h000, 9'h1FF - half_pos};
  assign amp        = {1'b0, prod[15:7]};
  // Base interval length in clocks, less one
  always_comb begin
    unique case (cfg_q.step_interval_mult)
      2'b00: mult_m1 = `FSC_MULT1_M1;
      2'b01: mult_m1 = `FSC_MULT5_M1;
      2'b10: mult_m1 = `FSC_MULT100_M1;
      2'b11: mult_m1 = `FSC_MULT500_M1;
    endcase
  end
  // Sequencer, interval timer, accumulator and marker pulse counter
  always_comb begin
    state_d = state_q;
    freq_d  = freq_q;
    left_d  = left_q;
    phase_d = (state_q != FSC_IDLE) ? phase_next : phase_q; // Idle keeps phase at zero
    pre_d   = pre_q;
    ivl_d   = ivl_q;
    pulse_d = (pulse_q != 3'h0) ? pulse_q - 3'h1 : 3'h0;
    step    = 1'b0;
    // Output-cycle mode ticks on accumulator wrap, else on the prescaler
    tick    = cfg_q.step_interval_by_cycles ? (phase_q[23] & ~phase_next[23]) : (pre_q == mult_m1);
    if (state_q == FSC_RUN) begin
      if (cfg_q.control[`FSC_B_EXT_INC]) begin
        step = trig_rise;
      end else begin
        pre_d = (pre_q == mult_m1) ? 9'h000 : pre_q + 9'h001;
        if (tick) begin
          ivl_d = ivl_q + 11'h001;
          if (ivl_d >= cfg_q.step_interval) begin
            ivl_d = 11'h000;
            step  = 1'b1;
          end
        end
      end
    end
    if (step) begin
      freq_d  = cfg_q.step_neg ? freq_q - step_ext : freq_q + step_ext;
      left_d  = left_q - 12'h001;
      pulse_d = `FSC_PULSE_LEN;
      if (left_q == 12'h001) begin
        state_d = FSC_DONE; // Last frequency keeps running
      end
    end
    // In RUN the edge steps (external) or is ignored (internal), never restarts
    if (trig_rise && (state_q != FSC_RUN)) begin
      state_d = (cfg_q.step_count == 12'h000) ? FSC_DONE : FSC_RUN;
      freq_d  = cfg_q.start_frequency;
      left_d  = cfg_q.step_count;
      phase_d = 24'h000000;
      pre_d   = 9'h000;
      ivl_d   = 11'h000;
      pulse_d = 3'h0;
    end
    if (abort_rise) begin
      state_d = FSC_IDLE;
      freq_d  = 24'h000000;
      left_d  = 12'h000;
      phase_d = 24'h000000;
      pre_d   = 9'h000;
      ivl_d   = 11'h000;
      pulse_d = 3'h0;
    end else if (standby) begin
      state_d = state_q; // Frozen in place, resumes on release
      freq_d  = freq_q;
      left_d  = left_q;
      phase_d = phase_q;
      pre_d   = pre_q;
      ivl_d   = ivl_q;
      pulse_d = pulse_q;
    end
  end
  // Converter word, square and marker from the chosen state
  always_comb begin
    if (cfg_q.control[`FSC_B_SINE]) begin
      wave = phase_q[23] ? `FSC_MIDSCALE - amp : `FSC_MIDSCALE + amp;
    end else begin
      wave = phase_q[23] ? ~phase_q[22:13] : phase_q[22:13];
    end
    dac_d = (state_d == FSC_IDLE) ? `FSC_MIDSCALE : wave;
    if (standby && !abort_rise) begin
      dac_d = dac_q; // Output holds its present value
    end
    sq_d = cfg_q.control[`FSC_B_SQ_EN] & ~dac_d[9];
    if (!cfg_q.control[`FSC_B_MARK_EN]) begin
      mark_d = 1'b0;
    end else if (cfg_q.control[`FSC_B_MARK_SEL]) begin
      mark_d = (state_d == FSC_DONE);
    end else begin
      mark_d = (pulse_d != 3'h0);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= FSC_IDLE;
      freq_q  <= 24'h000000;
      left_q  <= 12'h000;
      phase_q <= 24'h000000;
      pre_q   <= 9'h000;
      ivl_q   <= 11'h000;
      pulse_q <= 3'h0;
      dac_q   <= `FSC_MIDSCALE;
      sq_q    <= 1'b0;
      mark_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      freq_q  <= freq_d;
      left_q  <= left_d;
      phase_q <= phase_d;
      pre_q   <= pre_d;
      ivl_q   <= ivl_d;
      pulse_q <= pulse_d;
      dac_q   <= dac_d;
      sq_q    <= sq_d;
      mark_q  <= mark_d;
    end
  end
  // Registered outputs, except scan_active_o, which is decoded from state_q
  assign dac_data_o                = dac_q;
  assign converter_output_enable_o = cfg_q.control[`FSC_B_DAC_EN];
  assign square_wave_out_o         = sq_q;
  assign scan_marker_out_o         = mark_q;
  assign scan_active_o             = (state_q == FSC_RUN);

endmodule : fsc_core
`default_nettype wire

// >>> verification/fsc_host_model.sv
// Host-side serial writer for the frequency-scan block.
// Assumes an 80 ns serial clock that idles high between frames.
`timescale 1ns/1ps
`default_nettype none
module fsc_host_model (
  // Serial write port
  output logic sclk_o,
  output logic frame_n_o,
  output logic serial_data_in_o
);
  // Idle: clock high, frame high
  initial begin
    sclk_o    = 1'b1;
    frame_n_o = 1'b1;
    serial_data_in_o   = 1'b0;
  end
  // One framed word, begun just after a core clock edge so every pin
  // moves at the same offset; data set on the rise, taken on the fall
  task automatic send_word(input logic [15:0] w);
    frame_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_data_in_o = w[i];
      #40 sclk_o = 1'b0; // 12.5 MHz, well inside the limit
      #40 sclk_o = 1'b1;
    end
    #40 frame_n_o = 1'b1;
    serial_data_in_o = ~w[0]; // Released line must not show a stale bit
  endtask : send_word
endmodule : fsc_host_model
`default_nettype wire

// >>> verification/fsc_core_properties.sv
// Port-level checks of the frequency-scan block.
// Assumes it is bound to fsc_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fsc_core_properties (
  // Clock, reset and pins
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       frame_select_n_i,
  input wire logic       scan_trigger_pin_i,
  input wire logic       scan_abort_pin_i,
  input wire logic       power_save_pin_i,
  // Outputs
  input wire logic [9:0] dac_data_o,
  input wire logic       converter_output_enable_o,
  input wire logic       square_wave_out_o,
  input wire logic       scan_marker_out_o,
  input wire logic       scan_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Quiet outputs, converter at midscale, after reset
  a_reset_vals: assert property ($past(rst_i) |-> dac_data_o == 10'h200
    && !scan_active_o && !scan_marker_out_o && !converter_output_enable_o)
    else $error("outputs not at reset values");
  a_trig_start: assert property ($rose(scan_trigger_pin_i) && !scan_active_o
    && !scan_abort_pin_i && !power_save_pin_i |-> ##[1:6] scan_active_o)
    else $error("trigger did not start scan");
  a_abort_mid: assert property ($rose(scan_abort_pin_i) && !power_save_pin_i
    |-> ##8 dac_data_o == 10'h200) else $error("abort left output off midscale");
  a_abort_idle: assert property ($rose(scan_abort_pin_i) && !power_save_pin_i
    |-> ##[1:6] !scan_active_o ##1 !scan_active_o[*3]) else $error("abort kept scan");
  // Square output and converter word leave the same register stage
  a_square_inv: assert property (square_wave_out_o
    |-> !dac_data_o[9]) else $error("square not inverted");
  a_marker_pulse: assert property ($rose(scan_marker_out_o) && scan_active_o
    |-> scan_marker_out_o[*4] ##1 !scan_marker_out_o) else $error("marker pulse width");
  a_standby_hold: assert property (power_save_pin_i[*5]
    |-> $stable(dac_data_o) && $stable(scan_active_o)) else $error("standby moved output");
  // Settings only change from a framed serial word
  a_cfg_framed: assert property (frame_select_n_i[*8]
    |-> $stable(converter_output_enable_o)) else $error("setting changed unframed");
endmodule : fsc_core_properties
bind fsc_core fsc_core_properties chk_u (.clk_i, .rst_i, .frame_select_n_i,
  .scan_trigger_pin_i, .scan_abort_pin_i, .power_save_pin_i, .dac_data_o,
  .converter_output_enable_o, .square_wave_out_o, .scan_marker_out_o, .scan_active_o);
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the frequency-scan block.
// Assumes fsc_host_model writes the serial port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i, rst_i, trig, abrt, ps, sclk, fr_n, sd;
  logic conv, sq, mk, act;
  logic [9:0] dac, d, a;
  int err_total, check_count, n;

  fsc_host_model host_u (.sclk_o(sclk), .frame_n_o(fr_n), .serial_data_in_o(sd));
  fsc_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .serial_shift_clock_i(sclk),
    .frame_select_n_i(fr_n), .serial_data_in_i(sd), .scan_trigger_pin_i(trig),
    .scan_abort_pin_i(abrt), .power_save_pin_i(ps), .dac_data_o(dac),
    .converter_output_enable_o(conv), .square_wave_out_o(sq),
    .scan_marker_out_o(mk), .scan_active_o(act));

  // 100 MHz core clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic wr(input logic [15:0] w);
    host_u.send_word(w);
    tick(8);
  endtask : wr
  // Held for four clocks so the synchroniser sees it
  task automatic pulse;
    trig = 1'b1;
    tick(4);
    trig = 1'b0;
    tick(4);
  endtask : pulse
  // Bounded wait on marker or active
  task automatic wait_for(input logic on_mk, input logic v);
    n = 0;
    while (((on_mk ? mk : act) !== v) && n < 300) begin
      tick(1);
      n++;
    end
    // A wait that runs out counts as a mismatch
    chk({9'h000, on_mk ? mk : act}, {9'h000, v});
  endtask : wait_for
  // Triangle rise per clock equals frequency / 2^13
  task automatic slope;
    a = dac;
    tick(1);
    d = dac - a;
  endtask : slope
  task automatic wrap_up;
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #100us;
    err_total++;
    wrap_up();
  end
  initial begin
    {err_total, check_count} = '0;
    {rst_i, trig, abrt, ps} = 4'h8;
    tick(3);
    rst_i = 1'b0;
    tick(1);
    chk(dac, 10'h200);
    chk({6'h0, conv, sq, mk, act}, 10'h000);
    // Triangle, square, pulse marker, internal stepping every 10 clocks
    wr(16'h0504); // Interval stepping selected
    wr(16'h1002);
    wr(16'h2000);
    wr(16'h3002);
    wr(16'hC000);
    wr(16'hD002);
    wr(16'h600A);
    chk({9'h0, conv}, 10'h001);
    pulse();
    wait_for(1'b0, 1'b1);
    chk({9'h0, act}, 10'h001);
    slope();
    chk(d, 10'h001);
    chk({9'h0, sq}, 10'h001); // Ramp still below midscale
    wait_for(1'b1, 1'b1);
    n = 0;
    while (mk === 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    chk(n[9:0], 10'h004);
    slope();
    chk(d, 10'h002);
    wait_for(1'b1, 1'b1);
    tick(5);
    slope();
    chk(d, 10'h003);
    wait_for(1'b0, 1'b0);
    chk({9'h0, act}, 10'h000);
    tick(40);
    slope();
    chk(d, 10'h003);
    // Standby freezes, then the scan carries on
    ps = 1'b1;
    tick(5);
    a = dac;
    tick(15);
    chk(dac, a);
    ps = 1'b0;
    tick(6);
    slope();
    chk(d, 10'h003);
    abrt = 1'b1; // Host resets after standby
    tick(8);
    chk(dac, 10'h200);
    abrt = 1'b0;
    // External stepping, end-of-scan marker
    wr(16'h052C); // External stepping selected
    pulse();
    wait_for(1'b0, 1'b1);
    tick(30);
    slope();
    chk(d, 10'h001);
    pulse();
    slope();
    chk(d, 10'h002);
    pulse();
    wait_for(1'b0, 1'b0);
    tick(3);
    chk({9'h0, mk}, 10'h001);
    wr(16'h0508);
    chk({9'h0, mk}, 10'h000);
    // Sine path sits above midscale early on, where the triangle is below
    wr(16'h0600);
    pulse();
    chk({9'h0, act}, 10'h001);
    chk({9'h0, dac > 10'h200}, 10'h001);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
